// ### rtl/test_bus_pkg.sv
// package: register map, reset values and mode codes of the test bus multiplexer
package test_bus_pkg;

  localparam int          APB_ADDR_W         = 12;
  localparam int          APB_DATA_W         = 32;
  localparam int          BUS_W              = 8;
  localparam int          MODE_W             = 5;

  localparam logic [11:0] MODE_SELECT_OFFSET = 12'h000;
  localparam logic [11:0] READBACK_OFFSET    = 12'h004;

  localparam int          MODE_LSB           = 0;
  localparam int          READBACK_BUS_LSB   = 0;
  localparam int          READBACK_STB_BIT   = 8;

  localparam logic [4:0]  MODE_SELECT_RESET  = 5'h00;
  localparam logic [7:0]  BUS_RESET          = 8'h00;
  localparam logic        STROBE_RESET       = 1'b0;

  typedef enum logic [4:0] {
    MODE_QUIET       = 5'b00000,
    MODE_RX_ACQ      = 5'b00001,
    MODE_TX_FIELD    = 5'b00010,
    MODE_RSSI        = 5'b00011,
    MODE_SQ1         = 5'b00100,
    MODE_SQ2_LO      = 5'b00101,
    MODE_CORR_MAG    = 5'b00110,
    MODE_FREQ_LO     = 5'b00111,
    MODE_PHASE_LO    = 5'b01000,
    MODE_NCO_LO      = 5'b01001,
    MODE_BITSYNC     = 5'b01010,
    MODE_CAL_TEST    = 5'b01100,
    MODE_CORR_I      = 5'b01101,
    MODE_CORR_Q      = 5'b01110,
    MODE_CHIP_ERR    = 5'b01111,
    MODE_NCO_HI      = 5'b10000,
    MODE_FREQ_HI     = 5'b10001,
    MODE_PHASE_ERR   = 5'b10010,
    MODE_IQ_ADC      = 5'b10101,
    MODE_CAL_ACC_LO  = 5'b11001,
    MODE_CAL_ACC_HI  = 5'b11010,
    MODE_FREQ_ACC_LO = 5'b11011,
    MODE_SQ2_HI      = 5'b11101
  } test_mode_type;

  typedef enum logic [0:0] {
    XFER_IDLE = 1'b0,
    XFER_WAIT = 1'b1
  } xfer_state_type;

endpackage : test_bus_pkg

// ### rtl/bit_sync2.sv
// two-flop level synchroniser
`timescale 1ns/1ns
module bit_sync2
  import test_bus_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb
  begin
    next_meta = rst_n_i ? async_i : 1'b0;
    next_sync = rst_n_i ? meta : 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    meta   <= next_meta;
    sync_o <= next_sync;
  end

endmodule : bit_sync2

// ### rtl/link_side.sv
// link-clock side: loads the test pins from the held word on each request toggle
`timescale 1ns/1ns
module link_side
  import test_bus_pkg::*;
(
  input  wire logic             clk_link_i,
  input  wire logic             rst_n_i,
  input  wire logic             req_toggle_i,
  input  wire logic [BUS_W-1:0] hold_bus_i,
  input  wire logic             hold_strobe_i,
  output logic                  ack_toggle_o,
  output logic [BUS_W-1:0]      test_bus_o,
  output logic                  test_strobe_out_o
);

  logic             link_rst_n;
  logic             req_sync;
  logic             next_ack;
  logic [BUS_W-1:0] next_bus;
  logic             next_strobe;

  // reset brought into this domain; its own synchroniser cannot be reset
  bit_sync2 u_rst_sync (
    .clk_i   (clk_link_i),
    .rst_n_i (1'b1),
    .async_i (rst_n_i),
    .sync_o  (link_rst_n)
  );

  bit_sync2 u_req_sync (
    .clk_i   (clk_link_i),
    .rst_n_i (link_rst_n),
    .async_i (req_toggle_i),
    .sync_o  (req_sync)
  );

  // hold word is stable until the ack returns, so it is safe to sample here
  always_comb
  begin
    next_ack    = ack_toggle_o;
    next_bus    = test_bus_o;
    next_strobe = test_strobe_out_o;
    if (!link_rst_n)
    begin
      next_ack    = 1'b0;
      next_bus    = BUS_RESET;
      next_strobe = STROBE_RESET;
    end
    else if (req_sync != ack_toggle_o)
    begin
      next_bus    = hold_bus_i;
      next_strobe = hold_strobe_i;
      next_ack    = req_sync;
    end
  end

  always_ff @(posedge clk_link_i)
  begin
    ack_toggle_o      <= next_ack;
    test_bus_o        <= next_bus;
    test_strobe_out_o <= next_strobe;
  end

endmodule : link_side

// ### rtl/internal_signal_test_bus_mux.sv
// top: mode register, test word multiplexer, link crossing and apb slave
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module internal_signal_test_bus_mux
  import test_bus_pkg::*;
(
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  clk_link_i,
  input  wire logic [APB_ADDR_W-1:0] paddr_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [APB_DATA_W-1:0] pwdata_i,
  input  wire logic [3:0]            pstrb_i,
  output logic [APB_DATA_W-1:0]      prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic                  sample_strobe_i,
  input  wire logic                  subsample_strobe_i,
  input  wire logic                  initial_detect_i,
  input  wire logic                  tx_symbol_marker_i,
  input  wire logic                  rssi_pulse_i,
  input  wire logic                  sq_valid_i,
  input  wire logic                  cal_clock_i,
  input  wire logic                  cal_tick_i,
  input  wire logic                  carrier_acquired_flag_i,
  input  wire logic                  energy_threshold_flag_i,
  input  wire logic [4:0]            rx_header_flags_i,
  input  wire logic                  internal_tx_power_enable_i,
  input  wire logic [5:0]            tx_field_start_i,
  input  wire logic                  carrier_energy_latched_i,
  input  wire logic                  carrier_energy_flag_i,
  input  wire logic [5:0]            rssi_value_i,
  input  wire logic [7:0]            signal_quality_one_i,
  input  wire logic [15:0]           signal_quality_two_i,
  input  wire logic [7:0]            correlator_magnitude_i,
  input  wire logic [18:0]           freq_register_i,
  input  wire logic [7:0]            phase_register_i,
  input  wire logic [15:0]           nco_register_i,
  input  wire logic [7:0]            bit_sync_accum_i,
  input  wire logic                  cal_disable_i,
  input  wire logic [4:0]            converter_calibration_code_i,
  input  wire logic [8:0]            correlator_i_i,
  input  wire logic [8:0]            correlator_q_i,
  input  wire logic [14:0]           chip_error_accum_i,
  input  wire logic [19:0]           nco_accum_i,
  input  wire logic [18:0]           lag_accum_i,
  input  wire logic [6:0]            carrier_phase_error_i,
  input  wire logic [2:0]            i_adc_i,
  input  wire logic [2:0]            q_adc_i,
  input  wire logic [23:0]           cal_accum_i,
  input  wire logic [15:0]           freq_accum_i,
  output logic [BUS_W-1:0]           test_bus_o,
  output logic                       test_strobe_out_o
);

  logic [MODE_W-1:0]     test_mode_select_reg;
  logic [MODE_W-1:0]     next_mode;
  logic [APB_DATA_W-1:0] next_prdata;
  logic                  next_pready;
  logic                  next_pslverr;
  logic [BUS_W-1:0]      sel_bus;
  logic                  sel_strobe;
  logic [BUS_W-1:0]      hold_bus;
  logic                  hold_strobe;
  logic [BUS_W-1:0]      next_hold_bus;
  logic                  next_hold_strobe;
  logic                  req_toggle;
  logic                  next_req;
  logic                  ack_sync;
  logic                  ack_toggle;
  xfer_state_type        xfer_state;
  xfer_state_type        next_xfer_state;
  logic                  apb_setup;
  logic                  apb_write_done;

  function automatic logic is_mapped(input logic [APB_ADDR_W-1:0] addr);
    is_mapped = (addr == MODE_SELECT_OFFSET) || (addr == READBACK_OFFSET);
  endfunction : is_mapped

  // word selection; reserved codes fall to default and read as zero
  always_comb
  begin
    sel_bus    = BUS_RESET;
    sel_strobe = STROBE_RESET;
    case (test_mode_select_reg)
      MODE_QUIET:
      begin
        sel_bus    = BUS_RESET;
        sel_strobe = 1'b0;
      end
      MODE_RX_ACQ:
      begin
        sel_bus    = {cal_tick_i, carrier_acquired_flag_i, energy_threshold_flag_i, rx_header_flags_i};
        sel_strobe = initial_detect_i;
      end
      MODE_TX_FIELD:
      begin
        sel_bus    = {cal_tick_i, internal_tx_power_enable_i, tx_field_start_i};
        sel_strobe = tx_symbol_marker_i;
      end
      MODE_RSSI:
      begin
        sel_bus    = {carrier_energy_latched_i, carrier_energy_flag_i, rssi_value_i};
        sel_strobe = rssi_pulse_i;
      end
      MODE_SQ1:
      begin
        sel_bus    = signal_quality_one_i;
        sel_strobe = sq_valid_i;
      end
      MODE_SQ2_LO:
      begin
        sel_bus    = signal_quality_two_i[7:0];
        sel_strobe = sq_valid_i;
      end
      MODE_SQ2_HI:
      begin
        sel_bus    = signal_quality_two_i[15:8];
        sel_strobe = sq_valid_i;
      end
      MODE_CORR_MAG:
      begin
        sel_bus    = correlator_magnitude_i;
        sel_strobe = sample_strobe_i;
      end
      MODE_FREQ_LO:
      begin
        sel_bus    = freq_register_i[18:11];
        sel_strobe = subsample_strobe_i;
      end
      MODE_PHASE_LO:
      begin
        sel_bus    = phase_register_i;
        sel_strobe = subsample_strobe_i;
      end
      MODE_NCO_LO:
      begin
        sel_bus    = nco_register_i[15:8];
        sel_strobe = subsample_strobe_i;
      end
      MODE_BITSYNC:
      begin
        sel_bus    = bit_sync_accum_i;
        sel_strobe = sample_strobe_i;
      end
      MODE_CAL_TEST:
      begin
        sel_bus    = {cal_tick_i, energy_threshold_flag_i, cal_disable_i, converter_calibration_code_i};
        sel_strobe = cal_clock_i;
      end
      MODE_CORR_I:
      begin
        sel_bus    = correlator_i_i[8:1];
        sel_strobe = sample_strobe_i;
      end
      MODE_CORR_Q:
      begin
        sel_bus    = correlator_q_i[8:1];
        sel_strobe = sample_strobe_i;
      end
      MODE_CHIP_ERR:
      begin
        sel_bus    = chip_error_accum_i[14:7];
        sel_strobe = 1'b0;
      end
      MODE_NCO_HI:
      begin
        sel_bus    = nco_accum_i[19:12];
        sel_strobe = sample_strobe_i;
      end
      MODE_FREQ_HI:
      begin
        sel_bus    = lag_accum_i[18:11];
        sel_strobe = sample_strobe_i;
      end
      MODE_PHASE_ERR:
      begin
        sel_bus    = {carrier_phase_error_i[6], carrier_phase_error_i};
        sel_strobe = sample_strobe_i;
      end
      MODE_IQ_ADC:
      begin
        sel_bus    = {2'b00, i_adc_i, q_adc_i};
        sel_strobe = sample_strobe_i;
      end
      MODE_CAL_ACC_LO:
      begin
        sel_bus    = cal_accum_i[7:0];
        sel_strobe = cal_accum_i[8];
      end
      MODE_CAL_ACC_HI:
      begin
        sel_bus    = cal_accum_i[16:9];
        sel_strobe = cal_accum_i[17];
      end
      MODE_FREQ_ACC_LO:
      begin
        sel_bus    = freq_accum_i[14:7];
        sel_strobe = freq_accum_i[15];
      end
      default:
      begin
        sel_bus    = BUS_RESET;
        sel_strobe = STROBE_RESET;
      end
    endcase
  end

  // toggle handshake; strobes shorter than a round trip reach the pins only if high in the XFER_IDLE sample cycle
  always_comb
  begin
    next_xfer_state  = xfer_state;
    next_req         = req_toggle;
    next_hold_bus    = hold_bus;
    next_hold_strobe = hold_strobe;
    if (!rst_n_i)
    begin
      next_xfer_state  = XFER_IDLE;
      next_req         = 1'b0;
      next_hold_bus    = BUS_RESET;
      next_hold_strobe = STROBE_RESET;
    end
    else
    begin
      case (xfer_state)
        XFER_IDLE:
        begin
          next_hold_bus    = sel_bus;
          next_hold_strobe = sel_strobe;
          next_req         = ~req_toggle;
          next_xfer_state  = XFER_WAIT;
        end
        XFER_WAIT:
        begin
          if (ack_sync == req_toggle)
          begin
            next_xfer_state = XFER_IDLE;
          end
        end
        default:
        begin
          next_xfer_state = XFER_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    xfer_state  <= next_xfer_state;
    req_toggle  <= next_req;
    hold_bus    <= next_hold_bus;
    hold_strobe <= next_hold_strobe;
  end

  bit_sync2 u_ack_sync (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_i),
    .async_i (ack_toggle),
    .sync_o  (ack_sync)
  );

  link_side u_link (
    .clk_link_i        (clk_link_i),
    .rst_n_i           (rst_n_i),
    .req_toggle_i      (req_toggle),
    .hold_bus_i        (hold_bus),
    .hold_strobe_i     (hold_strobe),
    .ack_toggle_o      (ack_toggle),
    .test_bus_o        (test_bus_o),
    .test_strobe_out_o (test_strobe_out_o)
  );

  // apb slave: one wait-free access phase after each setup cycle
  assign apb_setup      = psel_i && !penable_i;
  assign apb_write_done = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;

  always_comb
  begin
    next_mode    = test_mode_select_reg;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_prdata  = prdata_o;
    if (!rst_n_i)
    begin
      next_mode   = MODE_SELECT_RESET;
      next_prdata = '0;
    end
    else
    begin
      if (apb_setup)
      begin
        next_pready  = 1'b1;
        next_pslverr = !is_mapped(paddr_i);
        next_prdata  = '0;
        if (!pwrite_i && (paddr_i == MODE_SELECT_OFFSET))
        begin
          next_prdata[MODE_LSB +: MODE_W] = test_mode_select_reg;
        end
        else if (!pwrite_i && (paddr_i == READBACK_OFFSET))
        begin
          next_prdata[READBACK_BUS_LSB +: BUS_W] = hold_bus;
          next_prdata[READBACK_STB_BIT]          = hold_strobe;
        end
      end
      if (apb_write_done && (paddr_i == MODE_SELECT_OFFSET) && pstrb_i[0])
      begin
        next_mode = pwdata_i[MODE_LSB +: MODE_W];
      end
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    test_mode_select_reg <= next_mode;
    pready_o             <= next_pready;
    pslverr_o            <= next_pslverr;
    prdata_o             <= next_prdata;
  end

  a_mode_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && paddr_i == MODE_SELECT_OFFSET)
    |=> test_mode_select_reg == $past(pwdata_i[4:0]))
    else $error("mode register did not take written value");

  a_readback_mirror: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (psel_i && !penable_i && !pwrite_i && paddr_i == READBACK_OFFSET)
    |=> pready_o && prdata_o[7:0] == $past(hold_bus) && prdata_o[31:9] == 23'h000000)
    else $error("readback differs from held bus word");

  a_bitsync_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (test_mode_select_reg == 5'h0a) |-> sel_bus == bit_sync_accum_i && sel_strobe == sample_strobe_i)
    else $error("mode ten word wrong");

  a_chip_err_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (test_mode_select_reg == 5'h0f) |-> sel_bus == chip_error_accum_i[14:7] && !sel_strobe)
    else $error("mode fifteen word wrong");

  a_phase_err_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (test_mode_select_reg == 5'h12) |-> sel_bus[7] == carrier_phase_error_i[6] && sel_bus[6:0] == carrier_phase_error_i)
    else $error("mode eighteen word wrong");

  a_cal_accum_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (test_mode_select_reg == 5'h1a) |-> sel_bus == cal_accum_i[16:9] && sel_strobe == cal_accum_i[17])
    else $error("mode twenty-six word wrong");

  a_quiet_reserved: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (test_mode_select_reg inside {5'h00, 5'h0b, 5'h13, 5'h14, 5'h16, 5'h17, 5'h18, 5'h1c, 5'h1e, 5'h1f})
    |-> sel_bus == 8'h00 && !sel_strobe)
    else $error("quiet or reserved mode not zero");

  a_sq1_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (test_mode_select_reg == 5'h04) |-> sel_bus == signal_quality_one_i && sel_strobe == sq_valid_i)
    else $error("mode four word wrong");

  a_hold_stable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (xfer_state == XFER_WAIT) |=> $stable(hold_bus) || $past(ack_sync == req_toggle))
    else $error("held word changed during crossing");

  a_xfer_bounded: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (xfer_state == XFER_IDLE) |=> ##[1:40] (xfer_state == XFER_IDLE))
    else $error("crossing handshake stalled");

  c_mode_write: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    apb_write_done && paddr_i == MODE_SELECT_OFFSET);
  c_readback: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    psel_i && penable_i && !pwrite_i && paddr_i == READBACK_OFFSET && prdata_o[7:0] != 8'h00);
  c_unmapped: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    psel_i && penable_i && pslverr_o);
  c_cal_mode: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    test_mode_select_reg == 5'h1a && sel_strobe);

endmodule : internal_signal_test_bus_mux

// ### tb/test_equipment_model.sv
// bench instrument that watches the test pins from the link side
`timescale 1ns/1ns
module test_equipment_model
  import test_bus_pkg::*;
(
  input  wire logic             clk_link_i,
  input  wire logic [BUS_W-1:0] test_bus_i,
  input  wire logic             test_strobe_i,
  output logic [BUS_W:0]        seen_o
);
  // pins change on the rising link edge, so the falling edge is race free
  // starts away from the reset word so the reset check means something
  initial seen_o = 9'h1ff;
  always @(negedge clk_link_i)
    seen_o <= {test_strobe_i, test_bus_i};
endmodule : test_equipment_model

// ### tb/internal_signal_test_bus_mux_tb_top.sv
// testbench: mode table through apb, pins and readback compared
`timescale 1ns/1ns
module internal_signal_test_bus_mux_tb_top;
  import test_bus_pkg::*;
  logic clk_sys = 1'b0, clk_link = 1'b0, rst_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, er, tstb, chk, stb;
  logic [7:0] tbus, bus;
  logic [8:0] seen;
  logic [4:0] md;
  logic ss = 1'b1, sub = 1'b1, idet = 1'b1, txm = 1'b0, rp = 1'b1, sqv = 1'b1, calc = 1'b1, tick = 1'b0;
  logic acq = 1'b1, thr = 1'b1, pwr_en = 1'b1, cel = 1'b1, cef = 1'b0, dis = 1'b0;
  logic [4:0] hdr = 5'h15, code = 5'h13;
  logic [5:0] tfs = 6'h0a, rssi = 6'h2d;
  logic [7:0] q1 = 8'h91, mag = 8'h33, ph = 8'h6e, bsa = 8'h5a;
  logic [15:0] q2 = 16'he817, ncor = 16'hb400, facc = 16'hd280;
  logic [18:0] freq = 19'h63000, lag = 19'h26000;
  logic [8:0] ci = 9'h0e5, cq = 9'h1a2;
  logic [14:0] cea = 15'h2b80;
  logic [19:0] nacc = 20'h7e000;
  logic [6:0] cpe = 7'h4b;
  logic [2:0] ia = 3'h5, qa = 3'h3;
  logic [23:0] cala = 24'h032d3c;
  int err_count = 0, n_tests = 0, cyc = 0;
  // {check strobe, strobe, bus, mode}; reserved modes never selected
  logic [14:0] rows [23] = '{
    {2'b10, 8'h00, 5'd0}, {2'b11, 8'h75, 5'd1}, {2'b10, 8'h4a, 5'd2}, {2'b11, 8'had, 5'd3},
    {2'b11, 8'h91, 5'd4}, {2'b11, 8'h17, 5'd5}, {2'b11, 8'h33, 5'd6}, {2'b11, 8'hc6, 5'd7},
    {2'b11, 8'h6e, 5'd8}, {2'b11, 8'hb4, 5'd9}, {2'b11, 8'h5a, 5'd10}, {2'b11, 8'h53, 5'd12},
    {2'b11, 8'h72, 5'd13}, {2'b11, 8'hd1, 5'd14}, {2'b10, 8'h57, 5'd15}, {2'b11, 8'h7e, 5'd16},
    {2'b11, 8'h4c, 5'd17}, {2'b11, 8'hcb, 5'd18}, {2'b11, 8'h2b, 5'd21}, {2'b11, 8'h3c, 5'd25},
    {2'b11, 8'h96, 5'd26}, {2'b11, 8'ha5, 5'd27}, {2'b11, 8'he8, 5'd29}};

  always #10 clk_sys = ~clk_sys;
  // link clock: 125 ns period, offset from the system clock
  always
  begin
    #62 clk_link = 1'b1;
    #63 clk_link = 1'b0;
  end

  internal_signal_test_bus_mux internal_signal_test_bus_mux_inst (
    .clk_sys_i(clk_sys), .rst_n_i(rst_n), .clk_link_i(clk_link), .paddr_i(paddr), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .sample_strobe_i(ss), .subsample_strobe_i(sub),
    .initial_detect_i(idet), .tx_symbol_marker_i(txm), .rssi_pulse_i(rp), .sq_valid_i(sqv),
    .cal_clock_i(calc), .cal_tick_i(tick), .carrier_acquired_flag_i(acq), .energy_threshold_flag_i(thr),
    .rx_header_flags_i(hdr), .internal_tx_power_enable_i(pwr_en), .tx_field_start_i(tfs),
    .carrier_energy_latched_i(cel), .carrier_energy_flag_i(cef), .rssi_value_i(rssi),
    .signal_quality_one_i(q1), .signal_quality_two_i(q2), .correlator_magnitude_i(mag),
    .freq_register_i(freq), .phase_register_i(ph), .nco_register_i(ncor), .bit_sync_accum_i(bsa),
    .cal_disable_i(dis), .converter_calibration_code_i(code), .correlator_i_i(ci), .correlator_q_i(cq),
    .chip_error_accum_i(cea), .nco_accum_i(nacc), .lag_accum_i(lag), .carrier_phase_error_i(cpe),
    .i_adc_i(ia), .q_adc_i(qa), .cal_accum_i(cala), .freq_accum_i(facc), .test_bus_o(tbus),
    .test_strobe_out_o(tstb));

  test_equipment_model test_equipment_model_inst (
    .clk_link_i(clk_link), .test_bus_i(tbus), .test_strobe_i(tstb), .seen_o(seen));

  task finish_test;
    $display("mismatches %0d of %0d checks", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test

  task check(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
    n_tests++;
    if (seen_v !== exp_v)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp_v, seen_v);
    end
  endtask : check

  // setup, then access held until pready is seen at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    // no answer within the limit counts against the run
    if (pready !== 1'b1)
      err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // the crossing takes a few link cycles; bounded wait for the word
  task wait_pins(input logic [8:0] w, input logic c);
    int k;
    k = 0;
    while (k < 300 && !(seen[7:0] === w[7:0] && (!c || seen[8] === w[8])))
    begin
      @(posedge clk_sys);
      k++;
    end
  endtask : wait_pins

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      finish_test();
    end
  end

  initial
  begin
    // link side needs several of its own edges inside reset
    repeat (30) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_pins(9'h000, 1'b1);
    check("reset pins", {23'h0, seen}, 32'h0);
    apb(1'b0, MODE_SELECT_OFFSET, 32'h0, 4'hf);
    check("reset mode", rd, 32'h0);
    apb(1'b0, READBACK_OFFSET, 32'h0, 4'hf);
    check("reset readback", rd, 32'h0);
    foreach (rows[i])
    begin
      {chk, stb, bus, md} = rows[i];
      apb(1'b1, MODE_SELECT_OFFSET, {27'h0, md}, 4'hf);
      wait_pins({stb, bus}, chk);
      check("pins", {24'h0, seen[7:0]}, {24'h0, bus});
      if (chk)
        check("strobe", {31'h0, seen[8]}, {31'h0, stb});
      apb(1'b0, READBACK_OFFSET, 32'h0, 4'hf);
      check("readback", rd & (chk ? 32'hffffffff : 32'hfffffeff), {23'h0, stb & chk, bus});
      apb(1'b0, MODE_SELECT_OFFSET, 32'h0, 4'hf);
      check("mode", rd, {27'h0, md});
    end
    // upper write bits must be dropped by the five-bit selector
    apb(1'b1, MODE_SELECT_OFFSET, 32'hffffffea, 4'hf);
    apb(1'b0, MODE_SELECT_OFFSET, 32'h0, 4'hf);
    check("mode width", rd, 32'h0000000a);
    @(posedge clk_sys);
    bsa <= 8'ha7;
    wait_pins(9'h1a7, 1'b1);
    check("live accum", {23'h0, seen}, 32'h000001a7);
    apb(1'b1, MODE_SELECT_OFFSET, 32'h0000000f, 4'he);
    apb(1'b1, READBACK_OFFSET, 32'h0000000f, 4'hf);
    apb(1'b0, MODE_SELECT_OFFSET, 32'h0, 4'hf);
    check("strobe lane and readonly", rd, 32'h0000000a);
    apb(1'b1, 12'h100, 32'h0000000f, 4'hf);
    check("unmapped write err", {31'h0, er}, 32'h1);
    apb(1'b0, 12'h100, 32'h0, 4'hf);
    check("unmapped read", {er, rd[30:0]}, 32'h80000000);
    apb(1'b0, MODE_SELECT_OFFSET, 32'h0, 4'hf);
    check("mode kept", rd, 32'h0000000a);
    // mid-run reset: mode and pins fall back to quiet
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (30) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_pins(9'h000, 1'b1);
    check("rerun pins", {23'h0, seen}, 32'h0);
    apb(1'b0, MODE_SELECT_OFFSET, 32'h0, 4'hf);
    check("rerun mode", rd, 32'h0);
    apb(1'b0, READBACK_OFFSET, 32'h0, 4'hf);
    check("rerun readback", rd, 32'h0);
    finish_test();
  end
endmodule : internal_signal_test_bus_mux_tb_top
